// ---- design/bvc_defines.vh ----
// bvc_defines.vh: offsets, field positions, reset values and timing counts
// assumes: included by the converter register bank, clock of 125 MHz
`ifndef BVC_DEFINES_VH
`define BVC_DEFINES_VH

// ------------------------------------------------------------
// register subaddresses
// ------------------------------------------------------------
`define BVC_ADDR_BUCK1     8'h16
`define BVC_ADDR_BUCK2     8'h17
`define BVC_ADDR_APPLY     8'h1A

// ------------------------------------------------------------
// field layout and reset values
// ------------------------------------------------------------
`define BVC_BIT_PSKIP      7
`define BVC_BIT_RSVD       6
`define BVC_CODE_MSB       5
`define BVC_RST_BUCK1      8'hAB
`define BVC_RST_BUCK2      8'hB2
`define BVC_BIT_GO         0
`define BVC_BIT_ALT_APPLY  1

// ------------------------------------------------------------
// voltage encoding in millivolts
// ------------------------------------------------------------
`define BVC_MV_BASE        11'h352
`define BVC_MV_FINE_STEP   11'h00A
`define BVC_MV_COARSE_STEP 11'h019
`define BVC_CODE_KNEE      6'h32

// ------------------------------------------------------------
// blanking time
// ------------------------------------------------------------
`define BVC_CLK_HZ         125000000
`define BVC_BLANK_US       5000
`define BVC_BLANK_CYCLES   ((`BVC_BLANK_US * (`BVC_CLK_HZ / 1000000)))

`endif

// ---- design/bvc_regs.v ----
// bvc_regs.v: voltage control registers for the first two step-down converters
// assumes: a serial bus front end gives one-cycle write and read strobes with
// subaddress and data, and the password unlock state arrives as a level
`timescale 1ns/1ps
`include "bvc_defines.vh"

// How it works
// - bit 7 pulse skip enable, resets one
// - bits 5..0 voltage code, piecewise linear
// - second converter at 0x17, resets 0xB2
// - writes accepted only while password unlocked
// - an accepted write to 0x16 or 0x17 blanks that converter's monitoring 5 ms
// - voltage applied only after bit 0 or bit 1 of 0x1A set
// - first converter at 0x16, resets 0xAB
// - first converter protected, blanked, applied alike
module bvc_regs #(
    parameter BLANK_CYCLES = `BVC_BLANK_CYCLES
) (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire        wr_en_in,
    input  wire        rd_en_in,
    input  wire [7:0]  addr_in,
    input  wire [7:0]  wdata_in,
    input  wire        unlocked_in,
    input  wire        buck1_uv_in,
    input  wire        buck1_ov_in,
    input  wire        buck2_uv_in,
    input  wire        buck2_ov_in,
    output reg  [7:0]  rdata_out,
    output reg         rd_valid_out,
    output reg         wr_reject_out,
    output reg         buck1_pulse_skip_enable_out,
    output reg  [5:0]  buck1_voltage_code_out,
    output reg  [10:0] buck1_mv_out,
    output reg         buck2_pulse_skip_enable_out,
    output reg  [5:0]  buck2_voltage_code_out,
    output reg  [10:0] buck2_mv_out,
    output reg         buck1_blank_out,
    output reg         buck2_blank_out,
    output reg         buck1_fault_out,
    output reg         buck2_fault_out
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // millivolts for a code; fine steps up to the knee, coarse above it
    function [10:0] bvc_code_to_mv;
        input [5:0] code;
        begin
            if (code <= `BVC_CODE_KNEE) begin
                bvc_code_to_mv = `BVC_MV_BASE + {5'h00, code} * `BVC_MV_FINE_STEP;
            end else begin
                bvc_code_to_mv = `BVC_MV_BASE
                    + {5'h00, `BVC_CODE_KNEE} * `BVC_MV_FINE_STEP
                    + {5'h00, code - `BVC_CODE_KNEE} * `BVC_MV_COARSE_STEP;
            end
        end
    endfunction

    // stored image with reserved bit forced low
    function [7:0] bvc_image;
        input       pskip;
        input [5:0] code;
        begin
            bvc_image = {pskip, 1'b0, code};
        end
    endfunction

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    reg        buck1_pskip_r;
    reg [5:0]  buck1_code_r;
    reg        buck2_pskip_r;
    reg [5:0]  buck2_code_r;
    reg [31:0] buck1_blank_cnt_r;
    reg [31:0] buck2_blank_cnt_r;

    wire wr_ok     = wr_en_in & unlocked_in;
    wire wr_buck1  = wr_ok & (addr_in == `BVC_ADDR_BUCK1);
    wire wr_buck2  = wr_ok & (addr_in == `BVC_ADDR_BUCK2);
    wire apply_hit = wr_ok & (addr_in == `BVC_ADDR_APPLY)
                   & (wdata_in[`BVC_BIT_GO] | wdata_in[`BVC_BIT_ALT_APPLY]);
    wire protected_addr = (addr_in == `BVC_ADDR_BUCK1) | (addr_in == `BVC_ADDR_BUCK2);

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            buck1_pskip_r <= 1'b1;
            buck1_code_r  <= 6'h2B;
            buck2_pskip_r <= 1'b1;
            buck2_code_r  <= 6'h32;
        end else begin
            if (wr_buck1) begin
                buck1_pskip_r <= wdata_in[`BVC_BIT_PSKIP];
                buck1_code_r  <= wdata_in[`BVC_CODE_MSB:0];
            end
            if (wr_buck2) begin
                buck2_pskip_r <= wdata_in[`BVC_BIT_PSKIP];
                buck2_code_r  <= wdata_in[`BVC_CODE_MSB:0];
            end
        end
    end

    // ------------------------------------------------------------
    // blanking counters
    // ------------------------------------------------------------
    // a write restarts the window even if one is already running
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            buck1_blank_cnt_r <= 32'h00000000;
            buck2_blank_cnt_r <= 32'h00000000;
        end else begin
            if (wr_buck1) begin
                buck1_blank_cnt_r <= BLANK_CYCLES;
            end else if (buck1_blank_cnt_r != 32'h00000000) begin
                buck1_blank_cnt_r <= buck1_blank_cnt_r - 32'h00000001;
            end
            if (wr_buck2) begin
                buck2_blank_cnt_r <= BLANK_CYCLES;
            end else if (buck2_blank_cnt_r != 32'h00000000) begin
                buck2_blank_cnt_r <= buck2_blank_cnt_r - 32'h00000001;
            end
        end
    end

    wire buck1_blank_nxt = wr_buck1 | (buck1_blank_cnt_r > 32'h00000001);
    wire buck2_blank_nxt = wr_buck2 | (buck2_blank_cnt_r > 32'h00000001);

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out                   <= 8'h00;
            rd_valid_out                <= 1'b0;
            wr_reject_out               <= 1'b0;
            buck1_pulse_skip_enable_out <= 1'b1;
            buck1_voltage_code_out      <= 6'h2B;
            buck1_mv_out                <= 11'h500;
            buck2_pulse_skip_enable_out <= 1'b1;
            buck2_voltage_code_out      <= 6'h32;
            buck2_mv_out                <= 11'h546;
            buck1_blank_out             <= 1'b0;
            buck2_blank_out             <= 1'b0;
            buck1_fault_out             <= 1'b0;
            buck2_fault_out             <= 1'b0;
        end else begin
            rd_valid_out  <= rd_en_in;
            wr_reject_out <= wr_en_in & ~unlocked_in & protected_addr;
            if (rd_en_in) begin
                case (addr_in)
                    `BVC_ADDR_BUCK1: begin
                        rdata_out <= bvc_image(buck1_pskip_r, buck1_code_r);
                    end
                    `BVC_ADDR_BUCK2: begin
                        rdata_out <= bvc_image(buck2_pskip_r, buck2_code_r);
                    end
                    default: begin
                        rdata_out <= 8'h00;
                    end
                endcase
            end
            buck1_pulse_skip_enable_out <= buck1_pskip_r;
            buck2_pulse_skip_enable_out <= buck2_pskip_r;
            if (apply_hit) begin
                buck1_voltage_code_out <= buck1_code_r;
                buck1_mv_out           <= bvc_code_to_mv(buck1_code_r);
                buck2_voltage_code_out <= buck2_code_r;
                buck2_mv_out           <= bvc_code_to_mv(buck2_code_r);
            end
            buck1_blank_out <= buck1_blank_nxt;
            buck2_blank_out <= buck2_blank_nxt;
            buck1_fault_out <= (buck1_uv_in | buck1_ov_in) & ~buck1_blank_nxt;
            buck2_fault_out <= (buck2_uv_in | buck2_ov_in) & ~buck2_blank_nxt;
        end
    end

endmodule // bvc_regs

// ---- tb/bvc_regs_monitor.sv ----
// bvc_regs_monitor.sv: assertions on the converter register bank
// assumes: bound to bvc_regs, short blanking count in sims
`timescale 1ns/1ps
module bvc_regs_monitor #(parameter BLANK_CYCLES = 20) (
    input wire logic clk_in, rst_n_in, wr_en_in, rd_en_in, unlocked_in,
    input wire logic [7:0] addr_in, wdata_in, rdata_out,
    input wire logic rd_valid_out, wr_reject_out, buck1_blank_out, buck2_blank_out,
    input wire logic buck1_pulse_skip_enable_out, buck2_fault_out,
    input wire logic [5:0] buck1_voltage_code_out, buck2_voltage_code_out,
    input wire logic [10:0] buck1_mv_out, buck2_mv_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire wr_ok = wr_en_in && unlocked_in;
    wire go = wr_ok && addr_in == 8'h1A && wdata_in[1:0] != 2'h0;
    int  blank_cnt_r;
    function automatic int mv(logic [5:0] c);
        return c <= 6'h32 ? 850 + 10 * c : 1350 + 25 * (c - 6'h32);
    endfunction
    sequence s_b1_wr;
        wr_ok && addr_in == 8'h16;
    endsequence
    // a rewrite restarts the count, so only uninterrupted runs are measured
    always @(posedge clk_in or negedge rst_n_in)
        if (!rst_n_in) blank_cnt_r <= 0;
        else if (wr_ok && addr_in == 8'h16) blank_cnt_r <= 0;
        else if (buck1_blank_out) blank_cnt_r <= blank_cnt_r + 1;
        else blank_cnt_r <= 0;
    a_rsvd_zero: assert property (rd_valid_out |-> !rdata_out[6])
        else $error("reserved bit read as one");
    a_lock_reject: assert property (wr_en_in && !unlocked_in && addr_in[7:1] == 7'h0B
        |=> wr_reject_out) else $error("locked write not refused");
    a_open_accept: assert property (wr_ok |=> !wr_reject_out)
        else $error("unlocked write refused");
    a_blank_start: assert property (s_b1_wr |=> buck1_blank_out)
        else $error("first blanking not started");
    a_blank2_start: assert property (wr_ok && addr_in == 8'h17 |=> buck2_blank_out)
        else $error("second blanking not started");
    a_blank_length: assert property ($fell(buck1_blank_out) |-> blank_cnt_r == BLANK_CYCLES)
        else $error("blanking length wrong");
    a_fault_masked: assert property (buck2_blank_out |-> !buck2_fault_out)
        else $error("fault seen while blanked");
    a_pskip_follow: assert property (s_b1_wr |=> ##1
        buck1_pulse_skip_enable_out == $past(wdata_in[7], 2)) else $error("pskip wrong");
    a_code_held: assert property (!go |=> $stable(buck1_voltage_code_out)
        && $stable(buck2_voltage_code_out)) else $error("code moved without apply");
    a_mv_match: assert property (buck1_mv_out == mv(buck1_voltage_code_out)
        && buck2_mv_out == mv(buck2_voltage_code_out)) else $error("mv wrong");
endmodule // bvc_regs_monitor
bind bvc_regs bvc_regs_monitor #(.BLANK_CYCLES(BLANK_CYCLES)) bvc_regs_monitor_inst (.*);

// ---- tb/bvc_regs_tb.sv ----
// bvc_regs_tb.sv: self-checking bench for the converter register bank
// assumes: bench drives every port itself, blanking shortened to 20 cycles
`timescale 1ns/1ps
module bvc_regs_tb;
    localparam int BLANK = 20;
    logic clk_in = 0, rst_n_in = 0, wr_en_in = 0, rd_en_in = 0, unlocked_in = 0;
    logic b1_uv = 0, b1_ov = 0, b2_uv = 0, b2_ov = 0;
    logic [7:0] addr_in = 8'h00, wdata_in = 8'h00;
    wire [7:0] rdata_out;
    wire rd_valid_out, wr_reject_out, ps1, ps2, bl1, bl2, f1, f2;
    wire [5:0] c1, c2;
    wire [10:0] mv1, mv2;
    int fails = 0, num_checks = 0;
    int stored[2] = '{8'hAB, 8'hB2};
    int applied[2] = '{8'h2B, 8'h32};
    int codes[4] = '{8'h00, 8'h32, 8'h33, 8'h3F};
    int gos[4] = '{8'h01, 8'h02, 8'h04, 8'h03};
    bvc_regs #(.BLANK_CYCLES(BLANK)) bvc_regs_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .unlocked_in(unlocked_in), .buck1_uv_in(b1_uv), .buck1_ov_in(b1_ov),
        .buck2_uv_in(b2_uv), .buck2_ov_in(b2_ov), .rdata_out(rdata_out),
        .rd_valid_out(rd_valid_out), .wr_reject_out(wr_reject_out),
        .buck1_pulse_skip_enable_out(ps1), .buck1_voltage_code_out(c1), .buck1_mv_out(mv1),
        .buck2_pulse_skip_enable_out(ps2), .buck2_voltage_code_out(c2), .buck2_mv_out(mv2),
        .buck1_blank_out(bl1), .buck2_blank_out(bl2), .buck1_fault_out(f1),
        .buck2_fault_out(f2));
    task automatic chk(string what, logic [10:0] exp, logic [10:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s exp %0h got %0h", what, exp, got);
        end
    endtask
    function automatic int mv(int c);
        return c > 50 ? 1350 + 25 * (c - 50) : 850 + 10 * c;
    endfunction
    task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
        wr_en_in = w;
        rd_en_in = !w;
        addr_in = a;
        wdata_in = d;
        @(posedge clk_in);
        #1;
    endtask
    // strobes drop and one edge passes, so no strobe is assigned twice in a step
    task automatic idle;
        wr_en_in = 0;
        rd_en_in = 0;
        @(posedge clk_in);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        acc(1, a, d);
        chk("reject", !unlocked_in && a[7:1] == 7'h0B, wr_reject_out);
        if (unlocked_in && a[7:1] == 7'h0B) stored[a[0]] = d & 8'hBF;
        if (unlocked_in && a == 8'h1A && d[1:0] != 0) foreach (applied[i])
            applied[i] = stored[i] % 64;
        idle;
    endtask
    task automatic rd(logic [7:0] a);
        acc(0, a, 8'h00);
        chk("rdata", a[7:1] == 7'h0B ? stored[a[0]] : 0, rdata_out);
        chk("valid", 1, rd_valid_out);
        idle;
    endtask
    task automatic outs;
        @(posedge clk_in);
        #1 chk("pskip1", stored[0] >> 7, ps1);
        chk("pskip2", stored[1] >> 7, ps2);
        chk("code1", applied[0], c1);
        chk("code2", applied[1], c2);
        chk("mv1", mv(applied[0]), mv1);
        chk("mv2", mv(applied[1]), mv2);
    endtask
    task automatic end_of_test;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial forever #4 clk_in = !clk_in;
    // whole run is about 115 cycles, so over twenty times that is a hang
    initial begin
        #(8 * 3000);
        fails++;
        end_of_test;
    end
    initial begin
        void'($urandom(64485));
        repeat (8) @(posedge clk_in);
        #1 rst_n_in = 1;
        rd(8'h16);
        rd(8'h17);
        outs;
        wr(8'h16, 8'h01);
        rd(8'h16);
        $display("test reset and lock done");
        unlocked_in = 1;
        repeat (6) begin
            wr(8'h16 + 8'($urandom % 2), 8'($urandom));
            rd(8'h16);
            rd(8'h17);
            outs;
        end
        foreach (codes[i]) begin
            wr(8'h16, 8'(codes[i]));
            wr(8'h17, 8'(8'h80 | (63 - codes[i])));
            wr(8'h1A, 8'(gos[i]));
            outs;
        end
        rd(8'h20);
        rd(8'h1A);
        $display("test fields and apply done");
        b2_ov = 1;
        b1_uv = 1;
        wr(8'h17, 8'hB2);
        repeat (BLANK - 2) begin
            chk("fault2", 0, f2);
            chk("blank2", 1, bl2);
            @(posedge clk_in);
            #1 b2_uv = !b2_uv;
        end
        repeat (4) @(posedge clk_in);
        #1 chk("fault2", 1, f2);
        chk("fault1", 1, f1);
        chk("blank2", 0, bl2);
        chk("blank1", 0, bl1);
        $display("test blanking done");
        end_of_test;
    end
endmodule // bvc_regs_tb
